// ---- wdd_dma.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wdd_consts.svh"
module wdd_dma (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output wdd_pkg::wdd_mem_req_s mem_req,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output wdd_pkg::wdd_tx_job_s tx_job,
    output logic tx_start,
    input wire logic tx_done,
    input wire wdd_pkg::wdd_tx_result_s tx_result,
    input wire logic rx_frame_valid,
    input wire logic [11:0] rx_frame_len,
    output logic rx_frame_taken,
    output logic [11:0] rx_write_len,
    output logic rx_truncated,
    output logic dma_done_irq
);
    typedef enum {S_IDLE, S_TFETCH, S_TDEC, S_TSEND, S_TWB, S_RFETCH, S_RWAIT, S_RWB} wdd_state_e;
    wdd_state_e state_q;
    logic [31:0] ctrl_q, txbase_q, rxbase_q, txcfg_q, gain_q, exch_q;
    logic [31:0] tx_ptr_q, rx_ptr_q, rx_first_q;
    logic [15:0] rx_cnt_q;
    logic [2:0] widx_q;
    logic tx_paused_q, rx_paused_q, rx_turn_q;
    logic [31:0] ram_rdata, wb_word;
    logic ram_we;
    logic [2:0] ram_raddr;
    logic [31:0] w_cmd_q, w_len_q, w_fall_q, w_phy_q, w_misc_q, w_next_q, w_rts_q, w_buf_q;
    logic [31:0] rx_cmd_q;
    logic [11:0] rx_len_q;
    logic apb_wr, apb_rd;
    wdd_pkg::wdd_tx_job_s job_d;
    wdd_pkg::wdd_tx_result_s res_q;

    function automatic logic is_own(input logic [31:0] w);
        is_own = w[`WDD_OWN];
    endfunction : is_own

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    assign pready = 1'b1;

    // slave decode: reads of unmapped addresses answer zero with pslverr; writes to them are ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 32'h0000_0000;
            txbase_q <= 32'h0000_0000;
            rxbase_q <= 32'h0000_0000;
            txcfg_q <= 32'h0000_0000;
            gain_q <= 32'h0000_0000;
        end else if (apb_wr) begin
            unique case (paddr)
                `WDD_REG_CTRL: ctrl_q <= pwdata;
                `WDD_REG_TXBASE: txbase_q <= pwdata;
                `WDD_REG_RXBASE: rxbase_q <= pwdata;
                `WDD_REG_TXCFG: txcfg_q <= pwdata;
                `WDD_REG_GAINBASE: gain_q <= pwdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (apb_rd) begin
            pslverr <= 1'b0;
            unique case (paddr)
                `WDD_REG_CTRL: prdata <= ctrl_q;
                `WDD_REG_TXBASE: prdata <= txbase_q;
                `WDD_REG_RXBASE: prdata <= rxbase_q;
                `WDD_REG_STATUS: prdata <= {28'h0000000, rx_paused_q, tx_paused_q, 2'h0};
                `WDD_REG_TXCFG: prdata <= txcfg_q;
                `WDD_REG_GAINBASE: prdata <= gain_q;
                `WDD_REG_EXCH: prdata <= exch_q;
                `WDD_REG_RXCNT: prdata <= {16'h0000, rx_cnt_q};
                default: begin
                    prdata <= 32'h0000_0000;
                    pslverr <= 1'b1;
                end
            endcase
        end else if (!psel) begin
            pslverr <= 1'b0;
        end
    end

    wdd_desc_ram #(.DEPTH(8)) u_ram (
        .pclk(pclk),
        .we(ram_we),
        .waddr(widx_q),
        .wdata(mem_rdata),
        .raddr(ram_raddr),
        .rdata(ram_rdata)
    );
    assign ram_we = mem_ack && !mem_req.wr && (state_q == S_TFETCH);
    assign ram_raddr = widx_q;

    wdd_tx_decode u_dec (
        .w_cmd(w_cmd_q),
        .w_len(w_len_q),
        .w_fall(w_fall_q),
        .w_phy(w_phy_q),
        .w_misc(w_misc_q),
        .dur_mode(txcfg_q[2:0]),
        .multi_bssid(txcfg_q[8]),
        .ofdm_gain_base_reg(gain_q[7:0]),
        .job(job_d)
    );

    // status-form words written back; own cleared, dma-done cleared
    always_comb begin
        unique case (widx_q)
            `WDD_TXW_CMD: wb_word = {1'b0, 1'b0, w_cmd_q[29:28], 11'h000, res_q.underrun, res_q.success,
                res_q.rts_resend_count, res_q.frame_resend_count};
            `WDD_TXW_RTS: wb_word = {res_q.exchange_duration, 16'h0000};
            `WDD_TXW_BUF: wb_word = w_buf_q;
            `WDD_TXW_LEN: wb_word = {20'h00000, w_len_q[11:0]};
            `WDD_TXW_NEXT: wb_word = w_next_q;
            default: wb_word = 32'h0000_0000;
        endcase
        if (state_q == S_RWB) begin
            wb_word = {1'b0, rx_cmd_q[`WDD_EOR], 2'h3, 16'h0000, rx_len_q};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_IDLE;
            widx_q <= 3'h0;
            tx_ptr_q <= 32'h0000_0000;
            rx_ptr_q <= 32'h0000_0000;
            rx_first_q <= 32'h0000_0000;
            tx_paused_q <= 1'b0;
            rx_paused_q <= 1'b0;
            rx_turn_q <= 1'b0;
            mem_req <= '0;
            tx_start <= 1'b0;
            tx_job <= '0;
            res_q <= '0;
            exch_q <= 32'h0000_0000;
            rx_cmd_q <= 32'h0000_0000;
            rx_len_q <= 12'h000;
            rx_cnt_q <= 16'h0000;
            rx_frame_taken <= 1'b0;
            rx_write_len <= 12'h000;
            rx_truncated <= 1'b0;
            dma_done_irq <= 1'b0;
            {w_cmd_q, w_rts_q, w_buf_q, w_len_q, w_next_q, w_fall_q, w_phy_q, w_misc_q} <= '0;
        end else begin
            tx_start <= 1'b0;
            rx_frame_taken <= 1'b0;
            dma_done_irq <= 1'b0;
            if (apb_wr && paddr == `WDD_REG_TXBASE) begin
                tx_ptr_q <= pwdata;
                tx_paused_q <= 1'b0;
            end
            if (apb_wr && paddr == `WDD_REG_RXBASE) begin
                rx_ptr_q <= pwdata;
                rx_first_q <= pwdata;
                rx_paused_q <= 1'b0;
            end
            // poll writes to ctrl restart paused rings
            if (apb_wr && paddr == `WDD_REG_CTRL) begin
                tx_paused_q <= 1'b0;
                rx_paused_q <= 1'b0;
            end
            unique case (state_q)
                S_IDLE: begin
                    rx_turn_q <= !rx_turn_q;
                    if (ctrl_q[1] && !rx_paused_q && rx_turn_q) begin
                        widx_q <= 3'h0;
                        mem_req <= '{req: 1'b1, wr: 1'b0, addr: rx_ptr_q, wdata: 32'h0000_0000};
                        state_q <= S_RFETCH;
                    end else if (ctrl_q[0] && !tx_paused_q) begin
                        widx_q <= 3'h0;
                        mem_req <= '{req: 1'b1, wr: 1'b0, addr: tx_ptr_q, wdata: 32'h0000_0000};
                        state_q <= S_TFETCH;
                    end
                end
                S_TFETCH: if (mem_ack) begin
                    unique case (widx_q)
                        `WDD_TXW_CMD: w_cmd_q <= mem_rdata;
                        `WDD_TXW_RTS: w_rts_q <= mem_rdata;
                        `WDD_TXW_BUF: w_buf_q <= mem_rdata;
                        `WDD_TXW_LEN: w_len_q <= mem_rdata;
                        `WDD_TXW_NEXT: w_next_q <= mem_rdata;
                        `WDD_TXW_FALL: w_fall_q <= mem_rdata;
                        `WDD_TXW_PHY: w_phy_q <= mem_rdata;
                        default: w_misc_q <= mem_rdata;
                    endcase
                    if (widx_q == `WDD_TXW_CMD && !is_own(mem_rdata)) begin
                        mem_req <= '0;
                        tx_paused_q <= 1'b1;
                        state_q <= S_IDLE;
                    end else if (widx_q == 3'h7) begin
                        mem_req <= '0;
                        state_q <= S_TDEC;
                    end else begin
                        widx_q <= widx_q + 3'h1;
                        mem_req.addr <= mem_req.addr + 32'h0000_0004;
                    end
                end
                S_TDEC: begin
                    tx_job <= job_d;
                    if (job_d.power_step_direction == wdd_pkg::WDD_PWR_BAD) begin
                        tx_job.power_step_direction <= wdd_pkg::WDD_PWR_HOLD;
                    end
                    if (!job_d.use_frag_queue) begin
                        tx_job.frag_queue_size <= 16'h0000;
                    end
                    tx_start <= 1'b1;
                    state_q <= S_TSEND;
                end
                S_TSEND: if (tx_done) begin
                    res_q <= tx_result;
                    exch_q <= {16'h0000, tx_result.exchange_duration};
                    widx_q <= 3'h0;
                    state_q <= S_TWB;
                    mem_req <= '{req: 1'b1, wr: 1'b1, addr: tx_ptr_q, wdata: 32'h0000_0000};
                end
                S_TWB: begin
                    mem_req.wdata <= wb_word;
                    if (mem_ack && mem_req.wr) begin
                        if (widx_q == 3'h7) begin
                            mem_req <= '0;
                            dma_done_irq <= w_cmd_q[`WDD_DMAOK] && w_cmd_q[`WDD_LS] && ctrl_q[4];
                            tx_ptr_q <= w_next_q;
                            state_q <= S_IDLE;
                        end else begin
                            widx_q <= widx_q + 3'h1;
                            mem_req.addr <= mem_req.addr + 32'h0000_0004;
                        end
                    end
                end
                S_RFETCH: if (mem_ack) begin
                    if (!is_own(mem_rdata)) begin
                        mem_req <= '0;
                        rx_paused_q <= 1'b1;
                        state_q <= S_IDLE;
                    end else begin
                        rx_cmd_q <= mem_rdata;
                        mem_req <= '0;
                        state_q <= S_RWAIT;
                    end
                end
                S_RWAIT: if (rx_frame_valid) begin
                    if (rx_frame_len > rx_cmd_q[11:0]) begin
                        rx_write_len <= rx_cmd_q[11:0];
                        rx_truncated <= 1'b1;
                    end else begin
                        rx_write_len <= rx_frame_len;
                        rx_truncated <= 1'b0;
                    end
                    rx_len_q <= rx_frame_len;
                    rx_frame_taken <= 1'b1;
                    state_q <= S_RWB;
                    mem_req <= '{req: 1'b1, wr: 1'b1, addr: rx_ptr_q, wdata: 32'h0000_0000};
                end
                S_RWB: begin
                    mem_req.wdata <= wb_word;
                    if (mem_ack && mem_req.wr) begin
                        mem_req <= '0;
                        rx_cnt_q <= rx_cnt_q + 16'h0001;
                        if (rx_cmd_q[`WDD_EOR]) begin
                            rx_ptr_q <= rx_first_q;
                        end else begin
                            rx_ptr_q <= rx_ptr_q + 32'h0000_0010;
                        end
                        state_q <= S_IDLE;
                    end
                end
            endcase
        end
    end

    logic unused_ok;
    assign unused_ok = ^{ram_rdata, w_rts_q};

    property p_own_pause;
        @(posedge pclk) disable iff (!presetn)
        (state_q == S_TFETCH && mem_ack && widx_q == 3'h0 && !mem_rdata[`WDD_OWN])
            |=> tx_paused_q && state_q == S_IDLE;
    endproperty
    a_own_pause: assert property (p_own_pause) else $error("host-owned tx descriptor not paused");
    property p_rx_wrap;
        @(posedge pclk) disable iff (!presetn)
        (state_q == S_RWB && mem_ack && mem_req.wr && rx_cmd_q[`WDD_EOR]) |=> rx_ptr_q == rx_first_q;
    endproperty
    a_rx_wrap: assert property (p_rx_wrap) else $error("rx pointer did not wrap");
    property p_rx_cap;
        @(posedge pclk) disable iff (!presetn)
        rx_frame_taken |-> rx_write_len <= rx_cmd_q[11:0];
    endproperty
    a_rx_cap: assert property (p_rx_cap) else $error("rx write exceeds capacity");
    property p_next_link;
        @(posedge pclk) disable iff (!presetn)
        (state_q == S_TWB && mem_ack && mem_req.wr && widx_q == 3'h7) |=> tx_ptr_q == $past(w_next_q);
    endproperty
    a_next_link: assert property (p_next_link) else $error("next descriptor link not followed");
    property p_own_clear;
        @(posedge pclk) disable iff (!presetn)
        (mem_ack && mem_req.wr && (state_q == S_RWB || (state_q == S_TWB && widx_q == 3'h0)))
            |-> !mem_req.wdata[`WDD_OWN];
    endproperty
    a_own_clear: assert property (p_own_clear) else $error("ownership not cleared");
    property p_start_pulse;
        @(posedge pclk) disable iff (!presetn)
        tx_start |-> state_q == S_TSEND ##1 !tx_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("tx start not single pulse");
    property p_frag_gate;
        @(posedge pclk) disable iff (!presetn)
        (tx_start && !(txcfg_q[2:0] == 3'h1 || txcfg_q[2:0] == 3'h2)) |-> tx_job.frag_queue_size == 16'h0000;
    endproperty
    a_frag_gate: assert property (p_frag_gate) else $error("frag queue used outside mode 1 or 2");
    property p_rx_len;
        @(posedge pclk) disable iff (!presetn)
        (state_q == S_RWAIT && rx_frame_valid) |=> rx_len_q == $past(rx_frame_len);
    endproperty
    a_rx_len: assert property (p_rx_len) else $error("rx length not captured");
endmodule : wdd_dma
`default_nettype wire

// ---- wdd_consts.svh ----
`ifndef WDD_CONSTS_SVH
`define WDD_CONSTS_SVH
// apb register byte offsets
`define WDD_REG_CTRL 12'h000
`define WDD_REG_TXBASE 12'h004
`define WDD_REG_RXBASE 12'h008
`define WDD_REG_STATUS 12'h00C
`define WDD_REG_TXCFG 12'h040
`define WDD_REG_GAINBASE 12'h044
`define WDD_REG_EXCH 12'h048
`define WDD_REG_RXCNT 12'h04C
// descriptor word indices
`define WDD_TXD_WORDS 8
`define WDD_RXD_WORDS 4
`define WDD_TXW_CMD 3'h0
`define WDD_TXW_RTS 3'h1
`define WDD_TXW_BUF 3'h2
`define WDD_TXW_LEN 3'h3
`define WDD_TXW_NEXT 3'h4
`define WDD_TXW_FALL 3'h5
`define WDD_TXW_PHY 3'h6
`define WDD_TXW_MISC 3'h7
// field positions
`define WDD_OWN 31
`define WDD_DMAOK 30
`define WDD_EOR 30
`define WDD_LS 28
`define WDD_UDR 16
`define WDD_TOK 15
`define WDD_PIFS 18
`define WDD_LTSEL 16
`define WDD_GKEN 14
`define WDD_DGSEL 3
// timing
`define WDD_SIFS_NS 10000
`define WDD_CLK_NS 40
`define WDD_SIFS_CYC (`WDD_SIFS_NS / `WDD_CLK_NS)
`endif

// ---- wdd_pkg.sv ----
package wdd_pkg;
    typedef struct packed {
        logic req;
        logic wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } wdd_mem_req_s;
    typedef struct packed {
        logic [4:0] data_fall_limit;
        logic [3:0] rts_fall_limit;
        logic pifs;
        logic lifetime_select;
        logic [15:0] lifetime_bound;
        logic [4:0] preamble_bits;
        logic [15:0] frag_queue_size;
        logic use_frag_queue;
        logic [5:0] key_index;
        logic key_index_valid;
        logic [1:0] power_step_direction;
        logic [7:0] gain_base;
        logic [11:0] byte_count;
    } wdd_tx_job_s;
    typedef struct packed {
        logic underrun;
        logic success;
        logic [6:0] rts_resend_count;
        logic [7:0] frame_resend_count;
        logic [15:0] exchange_duration;
    } wdd_tx_result_s;
    typedef enum logic [1:0] {WDD_PWR_HOLD, WDD_PWR_UP, WDD_PWR_DOWN, WDD_PWR_BAD} wdd_pwr_e;
endpackage : wdd_pkg

// ---- wdd_desc_ram.sv ----
`timescale 1ns/1ps
`default_nettype none
// descriptor word store, registered read
module wdd_desc_ram #(
    parameter int DEPTH = 8
) (
    input wire logic pclk,
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] waddr,
    input wire logic [31:0] wdata,
    input wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic [31:0] rdata
);
    logic [31:0] mem [DEPTH];
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : wdd_desc_ram
`default_nettype wire

// ---- wdd_tx_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wdd_consts.svh"
// combinational decode of a fetched transmit command descriptor
module wdd_tx_decode (
    input wire logic [31:0] w_cmd,
    input wire logic [31:0] w_len,
    input wire logic [31:0] w_fall,
    input wire logic [31:0] w_phy,
    input wire logic [31:0] w_misc,
    input wire logic [2:0] dur_mode,
    input wire logic multi_bssid,
    input wire logic [7:0] ofdm_gain_base_reg,
    output wdd_pkg::wdd_tx_job_s job
);
    function automatic logic [4:0] preamble_len(input logic [1:0] code);
        unique case (code)
            2'h0: preamble_len = 5'h0A;
            2'h1: preamble_len = 5'h0C;
            2'h2: preamble_len = 5'h0E;
            2'h3: preamble_len = 5'h10;
        endcase
    endfunction : preamble_len
    always_comb begin
        job.byte_count = w_len[11:0];
        job.data_fall_limit = w_fall[31:27];
        job.rts_fall_limit = w_fall[26:23];
        job.pifs = w_fall[`WDD_PIFS];
        job.lifetime_select = w_fall[`WDD_LTSEL];
        job.lifetime_bound = w_fall[`WDD_LTSEL] ? w_phy[15:0] : {8'h00, w_fall[15:8]};
        job.preamble_bits = preamble_len(w_phy[30:29]);
        job.frag_queue_size = w_misc[31:16];
        job.use_frag_queue = (dur_mode == 3'h1) || (dur_mode == 3'h2);
        job.key_index = w_misc[13:8];
        job.key_index_valid = w_misc[`WDD_GKEN] && multi_bssid;
        job.power_step_direction = w_misc[5:4];
        job.gain_base = w_misc[`WDD_DGSEL] ? w_phy[27:20] : ofdm_gain_base_reg;
        if (w_cmd[11:0] == 12'h000) begin
            job.byte_count = w_len[11:0];
        end
    end
endmodule : wdd_tx_decode
`default_nettype wire

// ---- wdd_host_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
// system memory behind the dma port; answers after lat extra cycles
module wdd_host_mem (
    input wire logic pclk,
    input wire logic presetn,
    input wire wdd_pkg::wdd_mem_req_s mem_req,
    input wire logic [3:0] lat,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [0:511];
    logic [3:0] wait_q;
    initial begin
        for (int k = 0; k < 512; k++) mem[k] = 32'h0;
    end
    // lat of at least one keeps the ack off the first cycle of a word
    assign mem_ack = mem_req.req && (wait_q >= lat);
    // no answer pending: a pattern that moves every cycle while a request waits and reads zero when idle, not stale data
    assign mem_rdata = mem_ack ? mem[mem_req.addr[10:2]] : {8{wait_q}};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 4'h0;
        end else begin
            wait_q <= (mem_ack || !mem_req.req) ? 4'h0 : wait_q + 4'h1;
        end
    end
    always @(posedge pclk) begin
        if (mem_ack && mem_req.wr) mem[mem_req.addr[10:2]] <= mem_req.wdata;
    end
endmodule : wdd_host_mem
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wdd_consts.svh"
module tb;
    typedef struct packed {
        logic [2:0] mode;
        logic [4:0] pre;
        logic [1:0] dir;
        logic dmaok;
    } wdd_row_s;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = '0, rx_frame_len = '0, len;
    logic [31:0] pwdata = '0, prdata, mem_rdata, w, x;
    logic pready, pslverr, mem_ack, tx_start, tx_done = 1'b0, rx_frame_valid = 1'b0, e, fq;
    logic rx_frame_taken, rx_truncated, dma_done_irq;
    logic [11:0] rx_write_len;
    logic [3:0] lat = 4'h1;
    wdd_pkg::wdd_mem_req_s mem_req;
    wdd_pkg::wdd_tx_job_s tx_job, job;
    wdd_pkg::wdd_tx_result_s tx_result = '0;
    int fails = 0, num_checks = 0, irqs = 0, b;
    // spc code and power code of row i are both i; code 11 of power holds
    wdd_row_s rows [4] = '{'{3'h1, 5'h0A, 2'h0, 1'b1}, '{3'h2, 5'h0C, 2'h1, 1'b0},
        '{3'h0, 5'h0E, 2'h2, 1'b1}, '{3'h3, 5'h10, 2'h0, 1'b1}};
    wdd_dma DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .tx_job(tx_job),
        .tx_start(tx_start), .tx_done(tx_done), .tx_result(tx_result), .rx_frame_valid(rx_frame_valid),
        .rx_frame_len(rx_frame_len), .rx_frame_taken(rx_frame_taken), .rx_write_len(rx_write_len),
        .rx_truncated(rx_truncated), .dma_done_irq(dma_done_irq));
    wdd_host_mem mem_i (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .lat(lat),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    initial begin
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (dma_done_irq === 1'b1) irqs++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_job(input wdd_pkg::wdd_tx_job_s exp);
        num_checks++;
        if (tx_job !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t job %h exp %h", $time, tx_job, exp);
        end
    endtask : chk_job
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        w = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0);
        chk(w, exp);
        chk({31'h0, e}, {31'h0, err});
    endtask : rd
    task automatic await(input logic which);
        int k;
        for (k = 0; k < 3000; k++) begin
            @(posedge pclk);
            if ((which ? rx_frame_taken : tx_start) === 1'b1) break;
        end
        if (k == 3000) begin
            fails++;
            $display("CHECK FAILED t=%0t wait for pulse timed out", $time);
        end
    endtask : await
    task automatic rx(input logic [11:0] fl, input logic [11:0] wl, input int idx, input logic ring_last_marker);
        rx_frame_len <= fl;
        rx_frame_valid <= 1'b1;
        await(1'b1);
        chk({19'h0, rx_truncated, rx_write_len}, {19'h0, fl != wl, wl});
        rx_frame_valid <= 1'b0;
        for (int k = 0; k < 300 && mem_i.mem[idx][31] !== 1'b0; k++) @(posedge pclk);
        chk(mem_i.mem[idx] & 32'hD000_0FFF, {1'b0, ring_last_marker, 2'b01, 16'h0, fl});
    endtask : rx
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    initial begin
        #800000;
        fails++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge pclk);
        chk({28'h0, tx_start, rx_frame_taken, dma_done_irq, mem_req.req}, 32'h0);
        presetn <= 1'b1;
        rd(`WDD_REG_CTRL, 32'h0, 1'b0);
        rd(`WDD_REG_TXCFG, 32'h0, 1'b0);
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        rd(12'h010, 32'h0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            b = 32'h40 + i * 8;
            len = 12'h5A0 + 12'(i);
            fq = rows[i].mode == 3'h1 || rows[i].mode == 3'h2;
            lat <= i[0] ? 4'h5 : 4'h1;
            mem_i.mem[b] = {1'b1, rows[i].dmaok, 2'b11, 16'h0, len};
            mem_i.mem[b + 2] = 32'h0000_8000;
            mem_i.mem[b + 3] = {20'h0, len};
            mem_i.mem[b + 4] = 32'(b * 4 + 32);
            mem_i.mem[b + 5] = {5'h15, 4'h9, 4'h0, i[0], 1'b0, i[1], 8'h3C, 8'h0};
            mem_i.mem[b + 6] = {1'b0, i[1:0], 1'b0, 8'hA7, 4'h0, 16'hBEEF};
            mem_i.mem[b + 7] = {16'h0123, 2'b01, 6'h2A, 2'h0, i[1:0], i[0], 3'h0};
            apb(1'b1, `WDD_REG_TXCFG, {23'h0, 1'b1, 5'h0, rows[i].mode});
            if (i == 0) begin
                apb(1'b1, `WDD_REG_GAINBASE, 32'h5C);
                apb(1'b1, `WDD_REG_TXBASE, 32'h100);
            end
            irqs = 0;
            apb(1'b1, `WDD_REG_CTRL, 32'h11);
            await(1'b0);
            job = '{5'h15, 4'h9, i[0], i[1], i[1] ? 16'hBEEF : 16'h003C, rows[i].pre,
                fq ? 16'h0123 : 16'h0, fq, 6'h2A, 1'b1, rows[i].dir, i[0] ? 8'hA7 : 8'h5C, len};
            chk_job(job);
            tx_result <= '{i[0], ~i[0], 7'(i + 1), 8'(i + 2), 16'h0100 + 16'(i)};
            tx_done <= 1'b1;
            @(posedge pclk);
            tx_done <= 1'b0;
            for (int k = 0; k < 200; k++) begin
                apb(1'b0, `WDD_REG_STATUS, 32'h0);
                if (w[2] === 1'b1) break;
            end
            chk(w & 32'h4, 32'h4);
            x = {15'h0, i[0], ~i[0], 7'(i + 1), 8'(i + 2)};
            chk(mem_i.mem[b] & 32'hC001_FFFF, x);
            chk(mem_i.mem[b + 1] & 32'hFFFF_0000, {16'h0100 + 16'(i), 16'h0});
            chk(mem_i.mem[b + 4], 32'(b * 4 + 32));
            chk(mem_i.mem[b + 5] | mem_i.mem[b + 6] | mem_i.mem[b + 7], 32'h0);
            chk(32'(irqs), {31'h0, rows[i].dmaok});
        end
        rd(`WDD_REG_EXCH, 32'h0103, 1'b0);
        mem_i.mem[256] = {2'b10, 18'h0, 12'h040};
        mem_i.mem[258] = 32'h0000_9000;
        mem_i.mem[260] = {2'b11, 18'h0, 12'h010};
        mem_i.mem[262] = 32'h0000_A000;
        apb(1'b1, `WDD_REG_RXBASE, 32'h400);
        apb(1'b1, `WDD_REG_CTRL, 32'h12);
        rx(12'h030, 12'h030, 256, 1'b0);
        rx(12'h020, 12'h010, 260, 1'b1);
        mem_i.mem[256] = {2'b10, 18'h0, 12'h040};
        apb(1'b1, `WDD_REG_CTRL, 32'h12);
        rx(12'h00C, 12'h00C, 256, 1'b0);
        rd(`WDD_REG_RXCNT, 32'h3, 1'b0);
        for (int k = 0; k < 50 && w[3] !== 1'b1; k++) apb(1'b0, `WDD_REG_STATUS, 32'h0);
        chk(w, 32'h8);
        // mid-run reset: outputs drop at once, registers come back cleared
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({27'h0, tx_start, rx_frame_taken, dma_done_irq, mem_req.req, pslverr}, 32'h0);
        presetn <= 1'b1;
        rd(`WDD_REG_CTRL, 32'h0, 1'b0);
        rd(`WDD_REG_RXCNT, 32'h0, 1'b0);
        rd(`WDD_REG_STATUS, 32'h0, 1'b0);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
